//--- common/svs_defines.vh
// word map, field layout, masks and timing of the shared variable area
// assumes: includer works on a 200 MHz clock and 16-bit variable words
`ifndef SVS_DEFINES_VH
`define SVS_DEFINES_VH

// word indexes, byte address is four times the index
`define SVS_IDX_SCR_LAST 8'h0f
`define SVS_IDX_SEQ_LOCK 8'h10
`define SVS_IDX_SEQ_CTRL 8'h11
`define SVS_IDX_HSIZE 8'h12
`define SVS_IDX_VSIZE 8'h13
`define SVS_IDX_PRATE 8'h14
`define SVS_IDX_QFLAGS 8'h15
`define SVS_IDX_PIC_LOCK 8'h16
`define SVS_IDX_TC0 8'h17
`define SVS_IDX_TC1 8'h18
`define SVS_IDX_TREF 8'h19
`define SVS_IDX_STATUS 8'h1a
`define SVS_IDX_INTRA_Q 8'h40
`define SVS_IDX_NINTRA_Q 8'h80
`define SVS_IDX_LAST 8'hbf
`define SVS_WORDS 192

// used-bit masks per word kind
`define SVS_M_FULL 16'hffff
`define SVS_M_NONE 16'h0000
`define SVS_M_CTRL 16'h0007
`define SVS_M_SIZE 16'h0fff
`define SVS_M_PRATE 16'h000f
`define SVS_M_QFLAGS 16'h0003
`define SVS_M_QENT 16'h00ff
`define SVS_M_TC 16'h0fff
`define SVS_M_TREF 16'h03ff

// control and flag bits
`define SVS_B_FRESH 0
`define SVS_B_BS_GUARD 1
`define SVS_B_DEF_GUARD 2
`define SVS_B_LD_INTRA 0
`define SVS_B_LD_NINTRA 1

// lock values; the device claim value is arbitrary, anything but host or free
`define SVS_LOCK_FREE 16'h0000
`define SVS_LOCK_HOST 16'h4242
`define SVS_LOCK_DEV 16'h5a5a

// source of a microapplication write
`define SVS_SRC_PLAIN 2'b00
`define SVS_SRC_BSTREAM 2'b01
`define SVS_SRC_DEFAULT 2'b10

// defaults restored in playback preparation (plain values)
`define SVS_DEF_HSIZE 16'h0160
`define SVS_DEF_VSIZE 16'h00f0
`define SVS_DEF_PRATE 16'h0003

// bus answers
`define SVS_RESP_OKAY 2'b00
`define SVS_RESP_SLVERR 2'b10

// timing: 5 ns clock, 5 us longest hold, 0.5 us least poll wait
`define SVS_CLK_PS 5000
`define SVS_HOLD_PS 5000000
`define SVS_POLL_PS 500000
`define SVS_HOLD_CYC (`SVS_HOLD_PS / `SVS_CLK_PS)
`define SVS_POLL_CYC ((`SVS_POLL_PS + `SVS_CLK_PS - 1) / `SVS_CLK_PS)

`endif

//--- hw/svs_lock_agent.v
// device-side claim engine for one lock word at a time
// assumes: word port answers with a one-cycle ack a cycle after request
`timescale 1ns/1ps
`include "svs_defines.vh"

module svs_lock_agent (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // requester
  input wire lock_req,
  input wire lock_sel,
  input wire lock_release,
  output reg lock_held_reg,
  output reg lock_expired_reg,
  // word port
  output reg m_req,
  output reg m_we,
  output reg [7:0] m_addr,
  output reg [15:0] m_wdata,
  input wire m_ack,
  input wire [15:0] m_rdata
);

localparam ST_IDLE = 3'd0;
localparam ST_RD = 3'd1;
localparam ST_WR = 3'd2;
localparam ST_WAIT = 3'd3;
localparam ST_POLL = 3'd4;
localparam ST_HELD = 3'd5;
localparam ST_FREE = 3'd6;
localparam integer POLL_CYC = `SVS_POLL_CYC;
localparam integer HOLD_CYC = `SVS_HOLD_CYC;
// both counts fit eleven bits; cut on purpose
localparam [10:0] POLL_LAST = POLL_CYC[10:0] - 11'h001;
localparam [10:0] HOLD_LAST = HOLD_CYC[10:0] - 11'h001;

reg [2:0] state_reg;
reg sel_reg;
reg [10:0] cnt_reg;
wire [7:0] lock_idx = sel_reg ? `SVS_IDX_PIC_LOCK : `SVS_IDX_SEQ_LOCK;

always @* begin
  m_req = (state_reg == ST_RD) | (state_reg == ST_WR) |
          (state_reg == ST_POLL) | (state_reg == ST_FREE);
  m_we = (state_reg == ST_WR) | (state_reg == ST_FREE);
  m_addr = lock_idx;
  m_wdata = (state_reg == ST_WR) ? `SVS_LOCK_DEV : `SVS_LOCK_FREE;
end

always @(posedge aclk) begin
  lock_expired_reg <= 1'b0;
  if (!aresetn) begin
    state_reg <= ST_IDLE;
    sel_reg <= 1'b0;
    cnt_reg <= 11'h000;
    lock_held_reg <= 1'b0;
  end else begin
    case (state_reg)
      ST_IDLE: if (lock_req) begin
        sel_reg <= lock_sel;
        state_reg <= ST_RD;
      end
      ST_RD: if (m_ack) begin
        if (!lock_req) state_reg <= ST_IDLE;
        else if (m_rdata == `SVS_LOCK_FREE) state_reg <= ST_WR;
      end
      ST_WR: if (m_ack) begin
        cnt_reg <= 11'h000;
        state_reg <= ST_WAIT;
      end
      ST_WAIT: begin
        cnt_reg <= cnt_reg + 11'h001;
        if (cnt_reg == POLL_LAST) state_reg <= ST_POLL;
      end
      ST_POLL: if (m_ack) begin
        cnt_reg <= 11'h000;
        if (m_rdata == `SVS_LOCK_DEV) begin
          state_reg <= ST_HELD;
          lock_held_reg <= 1'b1;
        end else begin
          state_reg <= ST_RD;
        end
      end
      ST_HELD: begin
        cnt_reg <= cnt_reg + 11'h001;
        if (lock_release | (cnt_reg == HOLD_LAST)) begin
          lock_held_reg <= 1'b0;
          lock_expired_reg <= ~lock_release;
          state_reg <= ST_FREE;
        end
      end
      ST_FREE: if (m_ack) state_reg <= ST_IDLE;
      default: state_reg <= ST_IDLE;
    endcase
  end
end

endmodule // svs_lock_agent

//--- hw/svs_var_area.v
// shared variable area: scratch words, sequence and picture groups
// assumes: host on AXI4-Lite, microapplication on a same-clock word port
`timescale 1ns/1ps
`include "svs_defines.vh"

module svs_var_area (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // microapplication word port
  input wire ua_req,
  input wire ua_we,
  input wire [1:0] ua_src,
  input wire [7:0] ua_addr,
  input wire [15:0] ua_wdata,
  output wire ua_ack,
  output reg [15:0] ua_rdata,
  // microapplication lock requests
  input wire lock_req,
  input wire lock_sel,
  input wire lock_release,
  output wire lock_held,
  output wire lock_expired,
  // decoder events
  input wire ev_reset_cmd,
  input wire playback_preparation_state,
  input wire ev_seq_header,
  input wire ev_seq_end,
  input wire ev_gop_applied,
  input wire ev_gop,
  input wire tc_drop,
  input wire [4:0] tc_hours,
  input wire [5:0] tc_minutes,
  input wire [5:0] tc_seconds,
  input wire [5:0] tc_pictures,
  input wire ev_pic,
  input wire [9:0] picture_order_index,
  // validity
  output wire seq_valid,
  output wire pic_valid,
  output wire intra_q_valid,
  output wire nintra_q_valid
);

////////////////////////////////////////////////////////////////////////
// storage and helpers

reg [15:0] mem [0:`SVS_WORDS-1];
integer k;

function is_mapped;
  input [9:0] a;
  begin
    is_mapped = (a[9:8] == 2'b00) &&
                ((a[7:0] <= `SVS_IDX_STATUS) ||
                 ((a[7:0] >= `SVS_IDX_INTRA_Q) && (a[7:0] <= `SVS_IDX_LAST)));
  end
endfunction

// bits that exist in each word; all others stay zero
function [15:0] word_mask;
  input [7:0] a;
  begin
    if (a <= `SVS_IDX_SCR_LAST) word_mask = `SVS_M_FULL;
    else if (a >= `SVS_IDX_INTRA_Q) word_mask = `SVS_M_QENT;
    else begin
      case (a)
        `SVS_IDX_SEQ_LOCK: word_mask = `SVS_M_FULL;
        `SVS_IDX_PIC_LOCK: word_mask = `SVS_M_FULL;
        `SVS_IDX_SEQ_CTRL: word_mask = `SVS_M_CTRL;
        `SVS_IDX_HSIZE: word_mask = `SVS_M_SIZE;
        `SVS_IDX_VSIZE: word_mask = `SVS_M_SIZE;
        `SVS_IDX_PRATE: word_mask = `SVS_M_PRATE;
        `SVS_IDX_QFLAGS: word_mask = `SVS_M_QFLAGS;
        `SVS_IDX_TC0: word_mask = `SVS_M_TC;
        `SVS_IDX_TC1: word_mask = `SVS_M_TC;
        `SVS_IDX_TREF: word_mask = `SVS_M_TREF;
        default: word_mask = `SVS_M_NONE;
      endcase
    end
  end
endfunction

// sequence words that carry stream values
function is_seq_data;
  input [7:0] a;
  begin
    is_seq_data = ((a >= `SVS_IDX_HSIZE) && (a <= `SVS_IDX_QFLAGS)) ||
                  (a >= `SVS_IDX_INTRA_Q);
  end
endfunction

function is_pic_word;
  input [7:0] a;
  begin
    is_pic_word = (a >= `SVS_IDX_TC0) && (a <= `SVS_IDX_STATUS);
  end
endfunction

wire [15:0] ctrl_w = mem[`SVS_IDX_SEQ_CTRL];
wire [15:0] qflags_w = mem[`SVS_IDX_QFLAGS];
wire bs_guard = ctrl_w[`SVS_B_BS_GUARD];
wire def_guard = ctrl_w[`SVS_B_DEF_GUARD];

////////////////////////////////////////////////////////////////////////
// microapplication side: claim engine before the plain word port

wire ag_req;
wire ag_we;
wire [7:0] ag_addr;
wire [15:0] ag_wdata;
reg m_ack_reg;
reg m_ag_reg;

// one cycle after a served request; blocks a second serve
wire m_any = ag_req | ua_req;
wire m_go = m_any & ~m_ack_reg;
wire m_we = ag_req ? ag_we : ua_we;
wire [7:0] m_addr = ag_req ? ag_addr : ua_addr;
wire [15:0] m_wdata = ag_req ? ag_wdata : ua_wdata;
wire [1:0] m_src = ag_req ? `SVS_SRC_PLAIN : ua_src;
wire m_ok = is_mapped({2'b00, m_addr}) && (m_addr != `SVS_IDX_STATUS);

svs_lock_agent u_agent (
  .aclk(aclk),
  .aresetn(aresetn),
  .lock_req(lock_req),
  .lock_sel(lock_sel),
  .lock_release(lock_release),
  .lock_held_reg(lock_held),
  .lock_expired_reg(lock_expired),
  .m_req(ag_req),
  .m_we(ag_we),
  .m_addr(ag_addr),
  .m_wdata(ag_wdata),
  .m_ack(m_ack_reg & m_ag_reg),
  .m_rdata(ua_rdata)
);

assign ua_ack = m_ack_reg & ~m_ag_reg;

// stream and default writes to sequence data words dropped while their guard is set
wire m_sup = is_seq_data(m_addr) &
             (((m_src == `SVS_SRC_BSTREAM) & bs_guard) |
              ((m_src == `SVS_SRC_DEFAULT) & def_guard));
wire m_wr = m_go & m_we & m_ok & ~m_sup;

// control word: guards kept as stored
wire [15:0] m_ctrl_val = {13'h0000, ctrl_w[`SVS_B_DEF_GUARD:`SVS_B_BS_GUARD],
                          m_wdata[`SVS_B_FRESH]};
wire [15:0] m_wval = (m_addr == `SVS_IDX_SEQ_CTRL) ? m_ctrl_val :
                     (m_wdata & word_mask(m_addr));

always @(posedge aclk) begin
  if (!aresetn) begin
    m_ack_reg <= 1'b0;
    m_ag_reg <= 1'b0;
    ua_rdata <= 16'h0000;
  end else begin
    m_ack_reg <= m_go;
    if (m_go) begin
      m_ag_reg <= ag_req;
      ua_rdata <= m_ok ? mem[m_addr] : 16'h0000;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// host write channels

reg aw_got_reg;
reg w_got_reg;
reg [9:0] aw_idx_reg;
reg [15:0] w_data_reg;
reg [1:0] w_strb_reg;

// the word port wins a shared cycle; a busy decoder can stall the host
wire m_busy = m_go | ev_gop | ev_pic;
wire h_wr_go = aw_got_reg & w_got_reg & ~s_axi_bvalid & ~m_busy;
wire [7:0] aw_idx = aw_idx_reg[7:0];
wire aw_ok = is_mapped(aw_idx_reg);
wire aw_rw = aw_ok && !is_pic_word(aw_idx);
wire [15:0] h_old = mem[aw_idx];
wire [15:0] h_raw = {w_strb_reg[1] ? w_data_reg[15:8] : h_old[15:8],
                     w_strb_reg[0] ? w_data_reg[7:0] : h_old[7:0]};
// host cannot clear the pending flag
wire [15:0] h_ctrl_val = {13'h0000,
                          h_raw[`SVS_B_DEF_GUARD:`SVS_B_BS_GUARD],
                          h_raw[`SVS_B_FRESH] | ctrl_w[`SVS_B_FRESH]};
wire [15:0] h_wval = (aw_idx == `SVS_IDX_SEQ_CTRL) ? h_ctrl_val :
                     (h_raw & word_mask(aw_idx));
wire h_wr = h_wr_go & aw_rw;

assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_got_reg <= 1'b0;
    w_got_reg <= 1'b0;
    aw_idx_reg <= 10'h000;
    w_data_reg <= 16'h0000;
    w_strb_reg <= 2'b00;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `SVS_RESP_OKAY;
  end else begin
    if (s_axi_awvalid & s_axi_awready) begin
      aw_got_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid & s_axi_wready) begin
      w_got_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[15:0];
      w_strb_reg <= s_axi_wstrb[1:0];
    end
    if (h_wr_go) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok ? `SVS_RESP_OKAY : `SVS_RESP_SLVERR;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// host read channels

reg ar_got_reg;
reg [9:0] ar_idx_reg;
wire h_rd_go = ar_got_reg & ~s_axi_rvalid & ~m_busy;
wire ar_ok = is_mapped(ar_idx_reg);
wire [15:0] status_w;

assign s_axi_arready = ~ar_got_reg & ~s_axi_rvalid;

always @(posedge aclk) begin
  if (!aresetn) begin
    ar_got_reg <= 1'b0;
    ar_idx_reg <= 10'h000;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `SVS_RESP_OKAY;
  end else begin
    if (s_axi_arvalid & s_axi_arready) begin
      ar_got_reg <= 1'b1;
      ar_idx_reg <= s_axi_araddr[11:2];
    end
    if (h_rd_go) begin
      ar_got_reg <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ar_ok ? `SVS_RESP_OKAY : `SVS_RESP_SLVERR;
      if (!ar_ok) s_axi_rdata <= 32'h0000_0000;
      else if (ar_idx_reg[7:0] == `SVS_IDX_STATUS) s_axi_rdata <= {16'h0000, status_w};
      else s_axi_rdata <= {16'h0000, mem[ar_idx_reg[7:0]]};
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// pending flag and validity tracking

reg setup_q_reg;
reg seq_valid_reg;
reg tc_valid_reg;
reg tref_valid_reg;
wire setup_rise = playback_preparation_state & ~setup_q_reg;
wire setup_fall = ~playback_preparation_state & setup_q_reg;
wire def_restore = setup_rise & ~def_guard;

// pending value after this cycle's plain writes
wire fresh_base = (m_wr & (m_addr == `SVS_IDX_SEQ_CTRL)) ? m_wdata[`SVS_B_FRESH] :
                  (h_wr & (aw_idx == `SVS_IDX_SEQ_CTRL)) ? h_wval[`SVS_B_FRESH] :
                  ctrl_w[`SVS_B_FRESH];
wire fresh_set = (ev_seq_header & ~bs_guard) |
                 (ev_seq_end & ~def_guard) | def_restore;
// an event in the clearing cycle is kept
wire fresh_next = fresh_set | (fresh_base & ~ev_gop_applied);

always @(posedge aclk) begin
  if (!aresetn) begin
    setup_q_reg <= 1'b0;
    seq_valid_reg <= 1'b0;
    tc_valid_reg <= 1'b0;
    tref_valid_reg <= 1'b0;
  end else begin
    setup_q_reg <= playback_preparation_state;
    if (ev_reset_cmd) begin
      seq_valid_reg <= 1'b0;
      tc_valid_reg <= 1'b0;
      tref_valid_reg <= 1'b0;
    end else begin
      if (setup_fall) seq_valid_reg <= 1'b1;
      if (ev_gop) tc_valid_reg <= 1'b1;
      if (ev_pic) tref_valid_reg <= 1'b1;
    end
  end
end

assign seq_valid = seq_valid_reg;
assign pic_valid = tc_valid_reg & tref_valid_reg;
assign intra_q_valid = seq_valid_reg & qflags_w[`SVS_B_LD_INTRA];
assign nintra_q_valid = seq_valid_reg & qflags_w[`SVS_B_LD_NINTRA];
assign status_w = {12'h000, pic_valid, nintra_q_valid, intra_q_valid, seq_valid};

////////////////////////////////////////////////////////////////////////
// the variable words themselves

always @(posedge aclk) begin
  if (!aresetn) begin
    for (k = 0; k < `SVS_WORDS; k = k + 1) mem[k] <= 16'h0000;
  end else begin
    // device claims and releases land here too
    if (m_wr) mem[m_addr] <= m_wval;
    else if (h_wr) mem[aw_idx] <= h_wval;
    if (def_restore) begin
      mem[`SVS_IDX_HSIZE] <= `SVS_DEF_HSIZE;
      mem[`SVS_IDX_VSIZE] <= `SVS_DEF_VSIZE;
      mem[`SVS_IDX_PRATE] <= `SVS_DEF_PRATE;
      mem[`SVS_IDX_QFLAGS] <= 16'h0000;
    end
    if (ev_gop) begin
      mem[`SVS_IDX_TC0] <= {4'h0, tc_drop, tc_hours, tc_minutes};
      mem[`SVS_IDX_TC1] <= {4'h0, tc_seconds, tc_pictures};
    end
    if (ev_pic) mem[`SVS_IDX_TREF] <= {6'h00, picture_order_index};
    mem[`SVS_IDX_SEQ_CTRL][`SVS_B_FRESH] <= fresh_next;
    if (ev_reset_cmd) begin
      mem[`SVS_IDX_SEQ_LOCK] <= `SVS_LOCK_FREE;
      mem[`SVS_IDX_SEQ_CTRL] <= 16'h0000;
    end
  end
end

endmodule // svs_var_area

//--- verification/svs_checker.sv
// concurrent checks on the shared variable area top ports
// assumes: bound to svs_var_area, one clock, synchronous active-low reset
`timescale 1ns/1ps

module svs_checker (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus readiness
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // word port and lock agent
  input wire ua_ack,
  input wire lock_held,
  input wire lock_expired,
  // events and validity
  input wire ev_reset_cmd,
  input wire playback_preparation_state,
  input wire seq_valid,
  input wire pic_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam int HOLD_MAX = 1000;
  int hold_cnt;

  // counts cycles of one device hold
  always @(posedge aclk) begin
    if (!aresetn || !lock_held) hold_cnt <= 0;
    else hold_cnt <= hold_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read data");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_reset_invalid: assert property (disable iff (1'b0)
    !aresetn |=> !seq_valid && !pic_valid) else $error("groups valid after reset");
  a_cmd_invalid: assert property (ev_reset_cmd |=> !seq_valid && !pic_valid)
    else $error("groups valid after reset command");
  a_seq_valid_cause: assert property ($rose(seq_valid) |-> !playback_preparation_state)
    else $error("sequence valid during preparation");
  a_hold_bound: assert property (hold_cnt <= HOLD_MAX)
    else $error("device lock held too long");
  a_expire_release: assert property (lock_expired |-> ##[0:4] !lock_held)
    else $error("lock still held after expiry");
  a_ack_pulse: assert property (ua_ack |=> !ua_ack)
    else $error("word port ack longer than one cycle");
  a_expire_pulse: assert property (lock_expired |=> !lock_expired)
    else $error("expiry longer than one cycle");
  c_held: cover property ($rose(lock_held));
  c_expired: cover property (lock_expired);
  c_prep_end: cover property ($fell(playback_preparation_state));
endmodule // svs_checker

bind svs_var_area svs_checker svs_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .ua_ack(ua_ack), .lock_held(lock_held), .lock_expired(lock_expired),
  .ev_reset_cmd(ev_reset_cmd), .playback_preparation_state(playback_preparation_state), .seq_valid(seq_valid),
  .pic_valid(pic_valid));

//--- verification/svs_uapp_model.sv
// microapplication stand-in on the word port, one write per command
// assumes: same clock as the variable area, ack one cycle wide
`timescale 1ns/1ps

module svs_uapp_model (
  // clock
  input wire aclk,
  // command from the bench
  input wire go,
  input wire [1:0] src,
  input wire [7:0] addr,
  input wire [15:0] data,
  output logic busy = 1'b0,
  // word port
  output logic ua_req = 1'b0,
  output logic ua_we = 1'b0,
  output logic [1:0] ua_src = 2'b00,
  output logic [7:0] ua_addr = 8'h00,
  output logic [15:0] ua_wdata = 16'h0000,
  input wire ua_ack
);
  ////////////////////////////////////////
  always @(posedge aclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      ua_req <= 1'b1;
      ua_we <= 1'b1;
      ua_src <= src;
      ua_addr <= addr;
      ua_wdata <= data;
    end else if (ua_req && ua_ack) begin
      busy <= 1'b0;
      ua_req <= 1'b0;
      ua_we <= 1'b0;
      // released lines must not keep looking like the last request
      ua_addr <= ~ua_addr;
      ua_wdata <= ~ua_wdata;
    end
  end
endmodule // svs_uapp_model

//--- verification/svs_var_area_tb_top.sv
// bench for the shared variable area: host over axi4-lite, uapp model
// assumes: svs_defines.vh on the include path, checker bound separately
`timescale 1ns/1ps
`include "svs_defines.vh"

module svs_var_area_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rv;
  logic [1:0] rs, m_src = 0;
  logic [7:0] m_addr = 0;
  logic [15:0] m_data = 0;
  logic go = 0, lock_req = 0, lock_sel = 0, lock_release = 0, playback_preparation_state = 0;
  logic [5:0] evs = 0;
  logic [23:0] tc = 0;
  logic [9:0] poi = 0;
  wire awready, wready, bvalid, arready, rvalid, ua_req, ua_we, ua_ack, busy;
  wire lock_held, lock_expired, seq_valid, pic_valid, iqv, nqv;
  wire [1:0] bresp, rresp, ua_src;
  wire [31:0] rdata;
  wire [7:0] ua_addr;
  wire [15:0] ua_wdata, ua_rd;
  int err_total = 0, samples_checked = 0;

  always #2.5 aclk = ~aclk;

  svs_var_area svs_var_area_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ua_req(ua_req), .ua_we(ua_we),
    .ua_src(ua_src), .ua_addr(ua_addr), .ua_wdata(ua_wdata), .ua_ack(ua_ack),
    .ua_rdata(ua_rd),
    .lock_req(lock_req), .lock_sel(lock_sel), .lock_release(lock_release),
    .lock_held(lock_held), .lock_expired(lock_expired), .ev_reset_cmd(evs[0]),
    .playback_preparation_state(playback_preparation_state), .ev_seq_header(evs[1]), .ev_seq_end(evs[2]),
    .ev_gop_applied(evs[3]), .ev_gop(evs[4]), .tc_drop(tc[23]), .tc_hours(tc[22:18]),
    .tc_minutes(tc[17:12]), .tc_seconds(tc[11:6]), .tc_pictures(tc[5:0]), .ev_pic(evs[5]),
    .picture_order_index(poi), .seq_valid(seq_valid), .pic_valid(pic_valid),
    .intra_q_valid(iqv), .nintra_q_valid(nqv));

  svs_uapp_model svs_uapp_model_inst (.aclk(aclk), .go(go), .src(m_src), .addr(m_addr),
    .data(m_data), .busy(busy), .ua_req(ua_req), .ua_we(ua_we), .ua_src(ua_src),
    .ua_addr(ua_addr), .ua_wdata(ua_wdata), .ua_ack(ua_ack));

  ////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // handshakes judged at the falling edge, where nothing moves before the next rise
  task wr(input [7:0] i, input [31:0] d);
    bit a, w, b;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {2'b00, i, 2'b00, d, 3'b111};
    b = 0;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (a) awvalid <= 0;
      if (w) wvalid <= 0;
    end
    bready <= 0;
  endtask
  task rd(input [7:0] i);
    bit a, v;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {2'b00, i, 2'b00, 2'b11};
    v = 0;
    while (!v) begin
      @(negedge aclk);
      a = arvalid && arready;
      v = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (a) arvalid <= 0;
    end
    rready <= 0;
  endtask
  task rc(input [7:0] i, input [31:0] e);
    rd(i);
    chk("read data", e, rv);
    chk("read resp", `SVS_RESP_OKAY, rs);
  endtask
  task ua(input [1:0] s, input [7:0] a, input [15:0] d);
    @(posedge aclk);
    {m_src, m_addr, m_data, go} <= {s, a, d, 1'b1};
    @(posedge aclk);
    go <= 0;
    repeat (50) begin
      @(negedge aclk);
      if (!busy) break;
    end
  endtask
  task ev(input [5:0] m);
    @(posedge aclk);
    evs <= m;
    @(posedge aclk);
    evs <= 0;
    cyc(3);
  endtask
  task wheld;
    int n;
    n = 0;
    while (lock_held !== 1'b1 && n < 600) begin
      @(negedge aclk);
      n++;
    end
  endtask

  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end

  initial begin
    int n;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rc(`SVS_IDX_SEQ_LOCK, 0);
    rc(`SVS_IDX_SEQ_CTRL, 0);
    rc(`SVS_IDX_STATUS, 0);
    wr(0, 32'hffff_a5c3);
    wr(`SVS_IDX_SCR_LAST, 32'h0000_1234);
    rc(0, 32'h0000_a5c3);
    rc(`SVS_IDX_SCR_LAST, 32'h0000_1234);
    wr(8'h1b, 1);
    chk("write resp", `SVS_RESP_SLVERR, rs);
    rd(8'h1b);
    chk("read resp", `SVS_RESP_SLVERR, rs);
    chk("read data", 0, rv);
    wr(`SVS_IDX_HSIZE, 32'h0000_ffff);
    rc(`SVS_IDX_HSIZE, 32'h0000_0fff);
    wr(8'h7f, 32'h0000_ffff);
    rc(8'h7f, 32'h0000_00ff);
    wr(`SVS_IDX_NINTRA_Q, 32'h0000_1234);
    rc(`SVS_IDX_NINTRA_Q, 32'h0000_0034);
    // host claim: free, write own value, wait, reread
    rc(`SVS_IDX_SEQ_LOCK, 0);
    wr(`SVS_IDX_SEQ_LOCK, `SVS_LOCK_HOST);
    cyc(`SVS_POLL_CYC);
    rc(`SVS_IDX_SEQ_LOCK, `SVS_LOCK_HOST);
    wr(`SVS_IDX_SEQ_CTRL, 2);
    rc(`SVS_IDX_SEQ_CTRL, 2);
    ua(`SVS_SRC_BSTREAM, `SVS_IDX_HSIZE, 16'h0200);
    rc(`SVS_IDX_HSIZE, 32'h0000_0fff);
    ua(`SVS_SRC_PLAIN, `SVS_IDX_HSIZE, 16'h0200);
    chk("uapp read", 16'h0fff, ua_rd);
    rc(`SVS_IDX_HSIZE, 32'h0000_0200);
    ev(2);
    rc(`SVS_IDX_SEQ_CTRL, 2);
    wr(`SVS_IDX_SEQ_CTRL, 0);
    ev(2);
    rc(`SVS_IDX_SEQ_CTRL, 1);
    wr(`SVS_IDX_SEQ_CTRL, 6);
    rc(`SVS_IDX_SEQ_CTRL, 7);
    ua(`SVS_SRC_PLAIN, `SVS_IDX_SEQ_CTRL, 0);
    rd(`SVS_IDX_SEQ_CTRL);
    chk("guard bits", 6, rv & 6);
    ua(`SVS_SRC_DEFAULT, `SVS_IDX_VSIZE, 16'h0123);
    rc(`SVS_IDX_VSIZE, 0);
    ev(8);
    rc(`SVS_IDX_SEQ_CTRL, 6);
    ev(4);
    rc(`SVS_IDX_SEQ_CTRL, 6);
    wr(`SVS_IDX_SEQ_CTRL, 0);
    ev(4);
    rc(`SVS_IDX_SEQ_CTRL, 1);
    ev(8);
    rc(`SVS_IDX_SEQ_CTRL, 0);
    wr(`SVS_IDX_SEQ_LOCK, 0);
    playback_preparation_state <= 1;
    cyc(20);
    rc(`SVS_IDX_HSIZE, `SVS_DEF_HSIZE);
    rc(`SVS_IDX_VSIZE, `SVS_DEF_VSIZE);
    rc(`SVS_IDX_PRATE, `SVS_DEF_PRATE);
    rc(`SVS_IDX_QFLAGS, 0);
    rc(`SVS_IDX_SEQ_CTRL, 1);
    chk("seq valid", 0, seq_valid);
    playback_preparation_state <= 0;
    cyc(3);
    chk("seq valid", 1, seq_valid);
    wr(`SVS_IDX_SEQ_CTRL, 4);
    wr(`SVS_IDX_HSIZE, 32'h0000_0055);
    playback_preparation_state <= 1;
    cyc(20);
    rc(`SVS_IDX_HSIZE, 32'h0000_0055);
    playback_preparation_state <= 0;
    wr(`SVS_IDX_QFLAGS, 3);
    cyc(1);
    chk("intra valid", 1, iqv);
    chk("nintra valid", 1, nqv);
    wr(`SVS_IDX_QFLAGS, 2);
    cyc(1);
    chk("intra valid", 0, iqv);
    chk("pic valid", 0, pic_valid);
    tc <= 24'hfe_a57f;
    poi <= 10'h3ff;
    ev(16);
    ev(32);
    rc(`SVS_IDX_TC0, 32'h0000_0fea);
    rc(`SVS_IDX_TC1, 32'h0000_057f);
    rc(`SVS_IDX_TREF, 32'h0000_03ff);
    wr(`SVS_IDX_TC0, 0);
    rc(`SVS_IDX_TC0, 32'h0000_0fea);
    rc(`SVS_IDX_STATUS, 32'h0000_000d);
    wr(`SVS_IDX_SEQ_LOCK, `SVS_LOCK_HOST);
    ev(1);
    rc(`SVS_IDX_SEQ_LOCK, 0);
    rc(`SVS_IDX_SEQ_CTRL, 0);
    chk("seq valid", 0, seq_valid);
    chk("pic valid", 0, pic_valid);
    // device must not claim while the host holds the word
    wr(`SVS_IDX_SEQ_LOCK, `SVS_LOCK_HOST);
    lock_req <= 1;
    cyc(300);
    chk("lock held", 0, lock_held);
    rc(`SVS_IDX_SEQ_LOCK, `SVS_LOCK_HOST);
    wr(`SVS_IDX_SEQ_LOCK, 0);
    wheld;
    chk("lock held", 1, lock_held);
    @(posedge aclk);
    lock_req <= 0;
    rc(`SVS_IDX_SEQ_LOCK, `SVS_LOCK_DEV);
    n = 0;
    while (lock_expired !== 1'b1 && n < 1100) begin
      @(negedge aclk);
      n++;
    end
    chk("lock expired", 1, lock_expired);
    cyc(3);
    rc(`SVS_IDX_SEQ_LOCK, 0);
    lock_sel <= 1;
    lock_req <= 1;
    wheld;
    @(posedge aclk);
    lock_req <= 0;
    rc(`SVS_IDX_PIC_LOCK, `SVS_LOCK_DEV);
    lock_release <= 1;
    @(posedge aclk);
    lock_release <= 0;
    cyc(5);
    chk("lock held", 0, lock_held);
    rc(`SVS_IDX_PIC_LOCK, 0);
    report_and_stop;
  end
endmodule // svs_var_area_tb_top
